// *** pcnt_top.v ***
// Purpose: 24-bit pulse counter with wrap flag and two-wire readout
// Assumes: All pins are sampled by CLK_SYS_I, much faster than SCL
// Notes:   Read returns the snapshot high byte first
`timescale 1ns/1ps
`include "pcnt_regs.vh"

module pcnt_top #(
	parameter CNT_W      = `PCNT_CNT_W,
	parameter SLAVE_ADDR = `PCNT_SLAVE_ADDR
) (
	input  wire CLK_SYS_I,          // System clock, 125 MHz
	input  wire RESET_N_I,          // Synchronous reset, active low
	input  wire COUNT_PULSE_IN_I,   // External count input pin
	input  wire CNT_RST_N_I,        // Counter reset pin, active low
	input  wire SCL_I,              // Serial clock from host
	input  wire SDA_I,              // Serial data line level
	output reg  SDA_O,              // Serial data drive value, always 0
	output reg  SDA_OE_O,           // High while pulling data low
	output reg  WRAP_O              // Counter wrap flag
);

	// ****************************************************************
	// States
	// ****************************************************************
	localparam [6:0] ST_IDLE     = 7'h01;
	localparam [6:0] ST_ADDR     = 7'h02;
	localparam [6:0] ST_ADDR_ACK = 7'h04;
	localparam [6:0] ST_TX       = 7'h08;
	localparam [6:0] ST_TX_ACK   = 7'h10;
	localparam [6:0] ST_RX       = 7'h20;
	localparam [6:0] ST_RX_ACK   = 7'h40;

	// ****************************************************************
	// Byte select of the snapshot
	// ****************************************************************
	function [7:0] pcnt_byte;
		input [23:0] val;
		input [1:0]  idx;
		begin
			if (idx == `PCNT_BYTE_HI)
				pcnt_byte = val[23:16];
			else if (idx == `PCNT_BYTE_MID)
				pcnt_byte = val[15:8];
			else
				pcnt_byte = val[7:0];
		end
	endfunction

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	wire       pulse_s;
	wire       cnt_rst_n_s;
	wire [1:0] bus_s;

	pcnt_sync #(
		.W       (2),
		.RST_VAL (1'b0)
	) u_sync_cnt (
		.clk_i   (CLK_SYS_I),
		.rst_n_i (RESET_N_I),
		.async_i ({COUNT_PULSE_IN_I, CNT_RST_N_I}),
		.sync_o  ({pulse_s, cnt_rst_n_s})
	);

	pcnt_sync #(
		.W       (2),
		.RST_VAL (1'b1)
	) u_sync_bus (
		.clk_i   (CLK_SYS_I),
		.rst_n_i (RESET_N_I),
		.async_i ({SCL_I, SDA_I}),
		.sync_o  (bus_s)
	);

	wire scl_s = bus_s[1];
	wire sda_s = bus_s[0];

	// ****************************************************************
	// Counter and wrap flag
	// ****************************************************************
	reg [CNT_W-1:0] cnt_reg;
	reg             pulse_d_reg;

	wire pulse_rise = pulse_s & ~pulse_d_reg;

	always @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			cnt_reg     <= `PCNT_CNT_RST;
			pulse_d_reg <= 1'b0;
			WRAP_O      <= `PCNT_WRAP_RST;
		end else begin
			pulse_d_reg <= pulse_s;
			if (!cnt_rst_n_s) begin
				cnt_reg <= `PCNT_CNT_RST;
			end else if (pulse_rise) begin
				cnt_reg <= cnt_reg + 1'b1;
				if (cnt_reg == `PCNT_CNT_MAX)
					WRAP_O <= ~WRAP_O;
			end
		end
	end

	// ****************************************************************
	// Bus condition detection
	// ****************************************************************
	reg scl_d_reg;
	reg sda_d_reg;

	wire scl_rise = scl_s & ~scl_d_reg;
	wire scl_fall = ~scl_s & scl_d_reg;
	wire start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	// ****************************************************************
	// Serial slave
	// ****************************************************************
	reg [6:0]       state_reg;
	reg [2:0]       bit_reg;
	reg [7:0]       shift_reg;
	reg [1:0]       byte_reg;
	reg             read_reg;
	reg             nack_reg;
	reg [CNT_W-1:0] snap_reg;
	reg             got_reg;

	// Byte now due on the line, from the snapshot
	wire [7:0] tx_byte = pcnt_byte(snap_reg, byte_reg);

	wire [1:0] byte_inc = (byte_reg == `PCNT_NBYTES - 2'h1) ?
		`PCNT_BYTE_HI : byte_reg + 2'h1;

	always @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			state_reg <= ST_IDLE;
			bit_reg   <= 3'h0;
			shift_reg <= 8'h00;
			byte_reg  <= `PCNT_BYTE_HI;
			read_reg  <= 1'b0;
			nack_reg  <= 1'b0;
			snap_reg  <= `PCNT_CNT_RST;
			got_reg   <= 1'b0;
			SDA_O     <= 1'b0;
			SDA_OE_O  <= 1'b0;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
			SDA_O     <= 1'b0;
			if (start_c) begin
				state_reg <= ST_ADDR;
				bit_reg   <= 3'h0;
				byte_reg  <= `PCNT_BYTE_HI;
				snap_reg  <= cnt_reg;
				got_reg   <= 1'b0;
				SDA_OE_O  <= 1'b0;
			end else if (stop_c) begin
				state_reg <= ST_IDLE;
				SDA_OE_O  <= 1'b0;
			end else begin
				case (state_reg)
				ST_ADDR: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_s};
						bit_reg   <= bit_reg + 3'h1;
						if (bit_reg == `PCNT_BIT_LAST)
							got_reg <= 1'b1;
					// The SCL fall that ends START carries no bit
					end else if (scl_fall && got_reg &&
						shift_reg[7:1] == SLAVE_ADDR) begin
						read_reg  <= shift_reg[0];
						SDA_OE_O  <= 1'b1;
						state_reg <= ST_ADDR_ACK;
					end else if (scl_fall && got_reg) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall && read_reg) begin
						shift_reg <= tx_byte;
						SDA_OE_O  <= ~tx_byte[7];
						state_reg <= ST_TX;
					end else if (scl_fall) begin
						SDA_OE_O  <= 1'b0;
						state_reg <= ST_RX;
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						bit_reg <= bit_reg + 3'h1;
					end else if (scl_fall && bit_reg == 3'h0) begin
						SDA_OE_O  <= 1'b0;
						byte_reg  <= byte_inc;
						state_reg <= ST_TX_ACK;
					end else if (scl_fall) begin
						shift_reg <= {shift_reg[6:0], 1'b0};
						SDA_OE_O  <= ~shift_reg[6];
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						nack_reg <= sda_s;
					end else if (scl_fall && !nack_reg) begin
						shift_reg <= tx_byte;
						SDA_OE_O  <= ~tx_byte[7];
						state_reg <= ST_TX;
					end else if (scl_fall) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_RX: begin
					if (scl_rise) begin
						bit_reg <= bit_reg + 3'h1;
					end else if (scl_fall && bit_reg == 3'h0) begin
						SDA_OE_O  <= 1'b1;
						state_reg <= ST_RX_ACK;
					end
				end
				ST_RX_ACK: begin
					if (scl_fall) begin
						SDA_OE_O  <= 1'b0;
						state_reg <= ST_RX;
					end
				end
				default: begin
					SDA_OE_O  <= 1'b0;
					state_reg <= ST_IDLE;
				end
				endcase
			end
		end
	end

endmodule

// *** pcnt_regs.vh ***
// Purpose: Shared constants of the pulse counter with serial readout
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef PCNT_REGS_VH
`define PCNT_REGS_VH

// ****************************************************************
// Counter
// ****************************************************************
`define PCNT_CNT_W      24
`define PCNT_CNT_RST    24'h000000
`define PCNT_CNT_MAX    24'hffffff
`define PCNT_WRAP_RST   1'b0

// ****************************************************************
// Serial readout
// ****************************************************************
`define PCNT_SLAVE_ADDR 7'h32
`define PCNT_NBYTES     2'h3
`define PCNT_BIT_LAST   3'h7
`define PCNT_BYTE_HI    2'h0
`define PCNT_BYTE_MID   2'h1
`define PCNT_BYTE_LO    2'h2

`endif

// *** pcnt_sync.v ***
// Purpose: Two flip-flop synchroniser for a group of pin inputs
// Assumes: Inputs are asynchronous to clk_i
// Notes:   Only the second stage leaves the module
`timescale 1ns/1ps

module pcnt_sync #(
	parameter W       = 1,
	parameter RST_VAL = 1'b0
) (
	input  wire         clk_i,    // System clock
	input  wire         rst_n_i,  // Synchronous reset, active low
	input  wire [W-1:0] async_i,  // Raw pin levels
	output wire [W-1:0] sync_o    // Synchronised levels
);

	reg [W-1:0] meta_reg;
	reg [W-1:0] sync_reg;

	// ****************************************************************
	// Two stages per bit
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			always @(posedge clk_i) begin
				if (!rst_n_i) begin
					meta_reg[g] <= RST_VAL;
					sync_reg[g] <= RST_VAL;
				end else begin
					meta_reg[g] <= async_i[g];
					sync_reg[g] <= meta_reg[g];
				end
			end
		end
	endgenerate

	assign sync_o = sync_reg;

endmodule

// *** pcnt_top_assertions.sv ***
// Purpose: Port checker for pcnt_top
// Assumes: Bound in the bench top
// Notes:   Sees top ports only
`timescale 1ns/1ps
module pcnt_chk (
	input wire CLK_SYS_I,        // Clock
	input wire RESET_N_I,        // Reset
	input wire COUNT_PULSE_IN_I, // Count pin
	input wire CNT_RST_N_I,      // Counter reset
	input wire SCL_I,            // Serial clock
	input wire SDA_I,            // Data line
	input wire SDA_O,            // Drive value
	input wire SDA_OE_O,         // Drive enable
	input wire WRAP_O            // Wrap flag
);
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RESET_N_I);
	// ****
	// Checks
	// ****
	AST_DRIVE_LOW: assert property (SDA_O == 1'b0)
		else $error("drive value high");
	AST_RST_QUIET: assert property (disable iff (1'b0)
		!RESET_N_I |=> !SDA_OE_O && !WRAP_O) else $error("reset");
	AST_WRAP_INIT: assert property (disable iff (1'b0)
		$rose(RESET_N_I) |-> !WRAP_O) else $error("wrap init");
	AST_WRAP_CAUSE: assert property ($changed(WRAP_O) |->
		$past(COUNT_PULSE_IN_I, 2) || $past(COUNT_PULSE_IN_I, 3))
		else $error("wrap cause");
	AST_WRAP_KEEP: assert property ($fell(CNT_RST_N_I) |=>
		$stable(WRAP_O)[*3]) else $error("wrap cleared");
	AST_OE_SCL_LOW: assert property ($changed(SDA_OE_O) |-> !SCL_I)
		else $error("drive change at high");
	AST_OE_HOLD: assert property (SCL_I[*3] |-> $stable(SDA_OE_O))
		else $error("drive unstable");
	AST_IDLE_FREE: assert property (SCL_I[*8] |-> !SDA_OE_O)
		else $error("line held idle");
	cover property ($rose(SDA_OE_O));
	cover property ($fell(CNT_RST_N_I));
	cover property (SCL_I && $fell(SDA_I));
endmodule

// *** pcnt_host.sv ***
// Purpose: Serial host reading the count
// Assumes: Line pulled up in the bench
// Notes:   SCL low and high 5 clocks each
`timescale 1ns/1ps
module pcnt_host (
	input  wire clk_i,  // Clock
	input  wire sda_i,  // Line level
	output reg  scl_o,  // Serial clock
	output reg  pull_o  // Pulls line low
);
	integer   i;
	integer   k;
	reg       b;
	reg [7:0] sh;
	// ****
	// Bus cycles
	// ****
	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end
	task tk(input integer n);
		repeat (n) @(posedge clk_i);
	endtask
	task put(input v);
	begin
		tk(1);
		pull_o <= ~v;
		tk(4);
		scl_o <= 1'b1;
		tk(5);
		scl_o <= 1'b0;
	end
	endtask
	task get(output v);
	begin
		tk(1);
		pull_o <= 1'b0;
		tk(4);
		scl_o <= 1'b1;
		tk(3);
		v = sda_i;
		tk(2);
		scl_o <= 1'b0;
	end
	endtask
	task xfer(input [6:0] a, output ack, output [23:0] val);
	begin
		val = 24'h0;
		sh = {a, 1'b1};
		// START: line falls while SCL stands high
		tk(1);
		pull_o <= 1'b0;
		tk(4);
		scl_o <= 1'b1;
		tk(5);
		pull_o <= 1'b1;
		tk(5);
		scl_o <= 1'b0;
		for (i = 7; i >= 0; i = i - 1)
			put(sh[i]);
		get(b);
		ack = ~b;
		for (k = 0; k < 3 && ack; k = k + 1) begin
			for (i = 0; i < 8; i = i + 1) begin
				get(b);
				val = {val[22:0], b};
			end
			put(k == 2);
		end
		// STOP: line rises while SCL stands high
		tk(1);
		pull_o <= 1'b1;
		tk(4);
		scl_o <= 1'b1;
		tk(5);
		pull_o <= 1'b0;
		tk(5);
	end
	endtask
endmodule

// *** pulse_counter_i2c_readout_tb.sv ***
// Purpose: Self-checking bench for pcnt_top
// Assumes: Host model on the serial link
// Notes:   Count pin and SCL period 80 ns
`timescale 1ns/1ps
`include "pcnt_regs.vh"
module pulse_counter_i2c_readout_tb;
	reg         clk = 1'b0;
	reg         rst_n = 1'b0;
	reg         pin = 1'b0;
	reg         crn = 1'b1;
	wire        scl;
	wire        pull;
	wire        oe;
	wire        wrap;
	wire        line = ~oe & ~pull;
	integer     bad_count = 0;
	integer     samples_checked = 0;
	reg         ack;
	reg  [23:0] v;
	always #4 clk = ~clk;
	pcnt_top DUT (.CLK_SYS_I(clk), .RESET_N_I(rst_n),
		.COUNT_PULSE_IN_I(pin), .CNT_RST_N_I(crn), .SCL_I(scl),
		.SDA_I(line), .SDA_O(), .SDA_OE_O(oe), .WRAP_O(wrap));
	pcnt_host host (.clk_i(clk), .sda_i(line), .scl_o(scl), .pull_o(pull));
	// ****
	// Tasks
	// ****
	task ck(input string s, input [23:0] e, input [23:0] g);
	begin
		samples_checked = samples_checked + 1;
		if (g !== e) begin
			$display("wrong value %s exp %h got %h", s, e, g);
			bad_count = bad_count + 1;
		end
	end
	endtask
	task pulses(input integer n);
		repeat (n) begin
			@(posedge clk) pin <= 1'b1;
			repeat (5) @(posedge clk);
			pin <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
	task rd(input [6:0] a, input ea, input [23:0] e);
	begin
		host.xfer(a, ack, v);
		ck("ack", {23'h0, ea}, {23'h0, ack});
		if (ea)
			ck("count", e, v);
	end
	endtask
	task stop_test;
	begin
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	initial begin
		#400000;
		bad_count = bad_count + 1;
		stop_test;
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		ck("wrap", 24'h0, {23'h0, wrap});
		ck("oe", 24'h0, {23'h0, oe});
		pulses(5);
		rd(`PCNT_SLAVE_ADDR, 1'b1, 24'h5);
		pulses(1);
		rd(`PCNT_SLAVE_ADDR, 1'b1, 24'h6);
		rd(`PCNT_SLAVE_ADDR + 7'h1, 1'b0, 24'h0);
		$display("test count done");
		@(posedge clk) crn <= 1'b0;
		pulses(4);
		rd(`PCNT_SLAVE_ADDR, 1'b1, 24'h0);
		ck("wrap", 24'h0, {23'h0, wrap});
		@(posedge clk) crn <= 1'b1;
		pulses(3);
		rd(`PCNT_SLAVE_ADDR, 1'b1, 24'h3);
		$display("test hold done");
		fork
			rd(`PCNT_SLAVE_ADDR, 1'b1, 24'h3);
			begin
				repeat (20) @(posedge clk);
				pulses(4);
			end
		join
		rd(`PCNT_SLAVE_ADDR, 1'b1, 24'h7);
		$display("test snapshot done");
		stop_test;
	end
endmodule
bind pcnt_top pcnt_chk u_chk (.CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I),
	.COUNT_PULSE_IN_I(COUNT_PULSE_IN_I), .CNT_RST_N_I(CNT_RST_N_I),
	.SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
	.WRAP_O(WRAP_O));
